// >>> src/ppsm_defines.svh
// register offsets, field positions, reset values and codes for the pin select map
`ifndef PPSM_DEFINES_SVH
`define PPSM_DEFINES_SVH

// ----------------------------------------------------------------------------
// register offsets (word index on the register port)
// ----------------------------------------------------------------------------
`define PPSM_OFS_OSC_CTRL      8'h00
`define PPSM_OFS_STATUS        8'h01
`define PPSM_OFS_CAP_PAIR_A    8'h02
`define PPSM_OFS_CAP_PAIR_B    8'h03
`define PPSM_OFS_OUT_MAP_BASE  8'h10
`define PPSM_OUT_MAP_REGS      16

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define PPSM_FLD_LO_POS        0
`define PPSM_FLD_HI_POS        8
`define PPSM_FLD_W             5
`define PPSM_LOCK_BIT          6

// ----------------------------------------------------------------------------
// reset values and keys
// ----------------------------------------------------------------------------
`define PPSM_RST_OUT_FIELD     5'h00
`define PPSM_RST_CAP_FIELD     5'h1F
`define PPSM_RST_LOCK          1'b0
`define PPSM_KEY_FIRST         8'h46
`define PPSM_KEY_SECOND        8'h57

// ----------------------------------------------------------------------------
// remappable pins present per package variant
// ----------------------------------------------------------------------------
`define PPSM_PINS              32
`define PPSM_IMPL_44PIN        32'h03FF_EFFF
`define PPSM_IMPL_28PIN        32'h0000_EFFF

// ----------------------------------------------------------------------------
// output function codes
// ----------------------------------------------------------------------------
`define PPSM_FN_NULL           5'h00
`define PPSM_FN_CMP1           5'h01
`define PPSM_FN_CMP2           5'h02
`define PPSM_FN_UART1_TX_OUT           5'h03
`define PPSM_FN_UART1_RTS_OUT          5'h04
`define PPSM_FN_UART2_TX_OUT           5'h05
`define PPSM_FN_UART2_RTS_OUT          5'h06
`define PPSM_FN_SPI1_DATA      5'h07
`define PPSM_FN_SPI1_CLK       5'h08
`define PPSM_FN_SPI1_SEL       5'h09
`define PPSM_FN_SPI2_DATA      5'h0A
`define PPSM_FN_SPI2_CLK       5'h0B
`define PPSM_FN_SPI2_SEL       5'h0C
`define PPSM_FN_OC1            5'h12
`define PPSM_FN_OC2            5'h13
`define PPSM_FN_OC3            5'h14
`define PPSM_FN_OC4            5'h15
`define PPSM_FN_OC5            5'h16
`define PPSM_FN_CHARGE_PULSE   5'h1D
`define PPSM_FN_CMP3           5'h1E

`endif

// >>> src/ppsm_pkg.sv
// types shared by the pin select map block
package ppsm_pkg;

   // peripheral outputs that can be routed onto remappable pins
   typedef struct packed {
      logic comparator1_out;
      logic comparator2_out;
      logic comparator3_out;
      logic uart1_tx_out;
      logic uart1_rts_out;
      logic uart1_ir_clk;
      logic uart1_ir_mode;
      logic uart2_tx_out;
      logic uart2_rts_out;
      logic uart2_ir_clk;
      logic uart2_ir_mode;
      logic spi1_data_out;
      logic spi1_clock_out;
      logic spi1_select_out;
      logic spi2_data_out;
      logic spi2_clock_out;
      logic spi2_select_out;
      logic compare_out_1;
      logic compare_out_2;
      logic compare_out_3;
      logic compare_out_4;
      logic compare_out_5;
      logic charge_timing_pulse_out;
   } ppsm_periph_type;

   // register port request
   typedef struct packed {
      logic [7:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } ppsm_req_type;

   // unlock sequence states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_KEY1 = 3'b010,
      ST_KEY2 = 3'b100
   } ppsm_seq_type;

   // whole state of the block
   typedef struct packed {
      logic [31:0][4:0] out_map;
      logic [3:0][4:0]  cap_map;
      logic [31:0][4:0] out_shadow;
      logic [3:0][4:0]  cap_shadow;
      logic             map_write_lock;
      logic             lock_set_once;
      ppsm_seq_type     seq;
      logic [15:0]      rdata;
      logic [31:0]      pin_out;
      logic [31:0]      pin_oe;
      logic [3:0]       capture_in;
      logic             mismatch;
   } ppsm_state_type;

endpackage

// >>> src/ppsm_top.sv
// remappable pin select map with write lock, unlock sequence and shadow monitor
//
// Overview of operation
// - each output-map register holds two 5-bit fields, one per remappable pin
// - output code zero is the null function, pin disconnected from all outputs
// - codes 1-12 select comparators 1-2, both UARTs and both SPI outputs
// - codes 18-22 select compare outputs 1-5, 29 charge pulse, 30 comparator 3
// - every remappable pin output resets to the null function
// - UART request-to-send codes also carry the infrared bit clock
// - contention blocked: one source per pin, one pin per functional input
// - one input may feed many peripherals, one output may drive many pins
// - up to 32 pins; 28-pin lacks 12 and 16-31, 44-pin lacks 12 and 26-31
// - while locked, map writes complete but stored contents stay unchanged
// - the map write lock is bit 6 of the oscillator control register
// - the lock holds its value until changed again, never relocks itself
// - shadow copies of all map registers raise a mismatch reset on difference
// - single-session config set and lock once set: clearing refused until reset
// - single-session config reads set when unprogrammed, allowing one session
// - capture pair A: bits 12-8 capture 2 pin, 4-0 capture 1 pin, reset ones
// - capture pair B: bits 12-8 capture 4 pin, 4-0 capture 3 pin, reset ones
// - capture select bits 15-13 and 7-5 read zero and ignore writes
//
// The address map and strobed register access were chosen for this implementation.
`include "ppsm_defines.svh"

module ppsm_top #(
   parameter logic [31:0] P_PIN_IMPL = `PPSM_IMPL_44PIN
) (
   input  wire logic                     i_mclk,
   input  wire logic                     i_srst,
   input  wire ppsm_pkg::ppsm_req_type   i_req,
   input  wire ppsm_pkg::ppsm_periph_type i_periph,
   input  wire logic [31:0]              i_pin_in,
   input  wire logic                     i_single_session_lock_cfg,
   output logic [15:0]                   o_rdata,
   output logic [31:0]                   o_pin_out,
   output logic [31:0]                   o_pin_oe,
   output logic [3:0]                    o_capture_in,
   output logic                          o_map_write_lock,
   output logic                          o_cfg_mismatch_rst
);

   // -------------------------------------------------------------------------
   // decoders
   // -------------------------------------------------------------------------
   // peripheral output picked by a function code; nc codes give zero
   function automatic logic fn_source(input logic [4:0] code,
                                      input ppsm_pkg::ppsm_periph_type p);
      logic s;
      s = 1'b0;
      case (code)
         `PPSM_FN_CMP1:         s = p.comparator1_out;
         `PPSM_FN_CMP2:         s = p.comparator2_out;
         `PPSM_FN_UART1_TX_OUT:         s = p.uart1_tx_out;
         `PPSM_FN_UART1_RTS_OUT:        s = p.uart1_ir_mode ? p.uart1_ir_clk : p.uart1_rts_out;
         `PPSM_FN_UART2_TX_OUT:         s = p.uart2_tx_out;
         `PPSM_FN_UART2_RTS_OUT:        s = p.uart2_ir_mode ? p.uart2_ir_clk : p.uart2_rts_out;
         `PPSM_FN_SPI1_DATA:    s = p.spi1_data_out;
         `PPSM_FN_SPI1_CLK:     s = p.spi1_clock_out;
         `PPSM_FN_SPI1_SEL:     s = p.spi1_select_out;
         `PPSM_FN_SPI2_DATA:    s = p.spi2_data_out;
         `PPSM_FN_SPI2_CLK:     s = p.spi2_clock_out;
         `PPSM_FN_SPI2_SEL:     s = p.spi2_select_out;
         `PPSM_FN_OC1:          s = p.compare_out_1;
         `PPSM_FN_OC2:          s = p.compare_out_2;
         `PPSM_FN_OC3:          s = p.compare_out_3;
         `PPSM_FN_OC4:          s = p.compare_out_4;
         `PPSM_FN_OC5:          s = p.compare_out_5;
         `PPSM_FN_CHARGE_PULSE: s = p.charge_timing_pulse_out;
         `PPSM_FN_CMP3:         s = p.comparator3_out;
         default:               s = 1'b0;
      endcase
      return s;
   endfunction

   // code drives a pin at all: null and unused codes leave it floating
   function automatic logic fn_drives(input logic [4:0] code);
      logic d;
      d = 1'b0;
      case (code)
         `PPSM_FN_NULL:                      d = 1'b0;
         5'h0D, 5'h0E, 5'h0F, 5'h10, 5'h11: d = 1'b0;
         5'h17, 5'h18, 5'h19, 5'h1A, 5'h1B,
         5'h1C, 5'h1F:                       d = 1'b0;
         default:                            d = 1'b1;
      endcase
      return d;
   endfunction

   // -------------------------------------------------------------------------
   // state
   // -------------------------------------------------------------------------
   ppsm_pkg::ppsm_state_type st_r;
   ppsm_pkg::ppsm_state_type st_nxt;

   logic       osc_wr;
   logic [7:0] key;
   logic       map_wr;
   logic       lock_wr_ok;
   logic       lock_new;
   logic [3:0] out_idx;

   assign osc_wr  = i_req.wr && (i_req.addr == `PPSM_OFS_OSC_CTRL);
   assign key     = i_req.wdata[7:0];
   assign lock_new = i_req.wdata[`PPSM_LOCK_BIT];
   assign map_wr  = i_req.wr && !st_r.map_write_lock;
   assign out_idx = i_req.addr[3:0];
   // clearing is refused once the single-session option has seen the lock set
   assign lock_wr_ok = !(i_single_session_lock_cfg && st_r.lock_set_once && !lock_new);

   // -------------------------------------------------------------------------
   // next state
   // -------------------------------------------------------------------------
   // map, lock sequencing, shadow compare and pin routing in one process
   always_comb begin
      st_nxt = st_r;
      // unlock sequence: any other osc write restarts it
      if (osc_wr) begin
         case (st_r.seq)
            ppsm_pkg::ST_IDLE: begin
               st_nxt.seq = (key == `PPSM_KEY_FIRST) ? ppsm_pkg::ST_KEY1
                                                     : ppsm_pkg::ST_IDLE;
            end
            ppsm_pkg::ST_KEY1: begin
               st_nxt.seq = (key == `PPSM_KEY_SECOND) ? ppsm_pkg::ST_KEY2
                                                      : ppsm_pkg::ST_IDLE;
            end
            ppsm_pkg::ST_KEY2: begin
               st_nxt.seq = ppsm_pkg::ST_IDLE;
               if (lock_wr_ok) begin
                  st_nxt.map_write_lock = lock_new;
               end
               if (lock_new) begin
                  st_nxt.lock_set_once = 1'b1;
               end
            end
            default: st_nxt.seq = ppsm_pkg::ST_IDLE;
         endcase
      end
      // map writes land in both the live copy and its shadow
      if (map_wr) begin
         if (i_req.addr[7:4] == 4'(`PPSM_OFS_OUT_MAP_BASE >> 4)) begin
            st_nxt.out_map[{out_idx, 1'b0}] = i_req.wdata[`PPSM_FLD_LO_POS +: 5];
            st_nxt.out_map[{out_idx, 1'b1}] = i_req.wdata[`PPSM_FLD_HI_POS +: 5];
            st_nxt.out_shadow[{out_idx, 1'b0}] = i_req.wdata[`PPSM_FLD_LO_POS +: 5];
            st_nxt.out_shadow[{out_idx, 1'b1}] = i_req.wdata[`PPSM_FLD_HI_POS +: 5];
         end
         if (i_req.addr == `PPSM_OFS_CAP_PAIR_A) begin
            st_nxt.cap_map[0] = i_req.wdata[`PPSM_FLD_LO_POS +: 5];
            st_nxt.cap_map[1] = i_req.wdata[`PPSM_FLD_HI_POS +: 5];
            st_nxt.cap_shadow[0] = i_req.wdata[`PPSM_FLD_LO_POS +: 5];
            st_nxt.cap_shadow[1] = i_req.wdata[`PPSM_FLD_HI_POS +: 5];
         end
         if (i_req.addr == `PPSM_OFS_CAP_PAIR_B) begin
            st_nxt.cap_map[2] = i_req.wdata[`PPSM_FLD_LO_POS +: 5];
            st_nxt.cap_map[3] = i_req.wdata[`PPSM_FLD_HI_POS +: 5];
            st_nxt.cap_shadow[2] = i_req.wdata[`PPSM_FLD_LO_POS +: 5];
            st_nxt.cap_shadow[3] = i_req.wdata[`PPSM_FLD_HI_POS +: 5];
         end
      end
      // a live copy that drifts from its shadow means a disturbed cell
      st_nxt.mismatch = (st_r.out_map != st_r.out_shadow) ||
                        (st_r.cap_map != st_r.cap_shadow);
      // each pin has exactly one field, so two sources can never fight on it
      for (int i = 0; i < `PPSM_PINS; i++) begin
         st_nxt.pin_oe[i]  = P_PIN_IMPL[i] && fn_drives(st_r.out_map[i]);
         st_nxt.pin_out[i] = P_PIN_IMPL[i] && fn_drives(st_r.out_map[i]) &&
                             fn_source(st_r.out_map[i], i_periph);
      end
      // each capture input takes one pin; absent pins read as low
      for (int k = 0; k < 4; k++) begin
         st_nxt.capture_in[k] = P_PIN_IMPL[st_r.cap_map[k]] &&
                                i_pin_in[st_r.cap_map[k]];
      end
      // read data stands only in the cycle after the read strobe
      st_nxt.rdata = 16'h0000;
      if (i_req.rd) begin
         case (i_req.addr)
            `PPSM_OFS_OSC_CTRL: begin
               st_nxt.rdata[`PPSM_LOCK_BIT] = st_r.map_write_lock;
            end
            `PPSM_OFS_STATUS: begin
               st_nxt.rdata = {13'h0000, i_single_session_lock_cfg,
                               st_r.mismatch, st_r.lock_set_once};
            end
            `PPSM_OFS_CAP_PAIR_A: begin
               st_nxt.rdata = {3'h0, st_r.cap_map[1], 3'h0, st_r.cap_map[0]};
            end
            `PPSM_OFS_CAP_PAIR_B: begin
               st_nxt.rdata = {3'h0, st_r.cap_map[3], 3'h0, st_r.cap_map[2]};
            end
            default: begin
               if (i_req.addr[7:4] == 4'(`PPSM_OFS_OUT_MAP_BASE >> 4)) begin
                  st_nxt.rdata = {3'h0, st_r.out_map[{out_idx, 1'b1}],
                                  3'h0, st_r.out_map[{out_idx, 1'b0}]};
               end
            end
         endcase
      end
   end

   // -------------------------------------------------------------------------
   // registers
   // -------------------------------------------------------------------------
   // null function on every pin and all-ones capture selects after reset
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         st_r                <= '0;
         st_r.out_map        <= {32{`PPSM_RST_OUT_FIELD}};
         st_r.out_shadow     <= {32{`PPSM_RST_OUT_FIELD}};
         st_r.cap_map        <= {4{`PPSM_RST_CAP_FIELD}};
         st_r.cap_shadow     <= {4{`PPSM_RST_CAP_FIELD}};
         st_r.map_write_lock <= `PPSM_RST_LOCK;
         st_r.seq            <= ppsm_pkg::ST_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_rdata            = st_r.rdata;
   assign o_pin_out          = st_r.pin_out;
   assign o_pin_oe           = st_r.pin_oe;
   assign o_capture_in       = st_r.capture_in;
   assign o_map_write_lock   = st_r.map_write_lock;
   assign o_cfg_mismatch_rst = st_r.mismatch;

   // -------------------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------------------
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_srst);

   sequence s_key1;
      osc_wr && key == `PPSM_KEY_FIRST;
   endsequence
   sequence s_key2;
      osc_wr && key == `PPSM_KEY_SECOND;
   endsequence
   // the lock write itself: keys need not sit in adjacent cycles, only in adjacent osc writes
   sequence s_lock_step;
      osc_wr && st_r.seq == ppsm_pkg::ST_KEY2;
   endsequence

   a_first_key: assert property (
      s_key1 ##0 (st_r.seq == ppsm_pkg::ST_IDLE) |=> st_r.seq == ppsm_pkg::ST_KEY1)
      else $error("first key not taken");

   a_second_key: assert property (
      s_key2 ##0 (st_r.seq == ppsm_pkg::ST_KEY1) |=> st_r.seq == ppsm_pkg::ST_KEY2)
      else $error("second key not taken");

   a_lock_blocks_map: assert property (
      (i_req.wr && st_r.map_write_lock && i_req.addr != `PPSM_OFS_OSC_CTRL)
      |=> $stable(st_r.out_map) && $stable(st_r.cap_map))
      else $error("map changed while locked");

   a_unlock_sequence: assert property (
      s_lock_step ##0 lock_wr_ok
      |=> o_map_write_lock == $past(lock_new))
      else $error("unlock sequence did not move the lock");

   a_lock_holds: assert property (
      !osc_wr |=> $stable(o_map_write_lock))
      else $error("lock changed without a write");

   a_one_way_lock: assert property (
      (i_single_session_lock_cfg && st_r.lock_set_once && o_map_write_lock)
      |=> o_map_write_lock)
      else $error("single-session lock was cleared");

   a_bare_lock_write: assert property (
      (osc_wr && st_r.seq == ppsm_pkg::ST_IDLE) |=> $stable(o_map_write_lock))
      else $error("lock moved without keys");

   a_null_no_drive: assert property (
      (st_r.out_map[0] == `PPSM_FN_NULL) |=> !o_pin_oe[0])
      else $error("null code drives pin");

   a_absent_pin_quiet: assert property (
      !P_PIN_IMPL[12] |-> !o_pin_oe[12] && !o_pin_out[12])
      else $error("unimplemented pin driven");

   a_cap_reserved_zero: assert property (
      (i_req.rd && i_req.addr == `PPSM_OFS_CAP_PAIR_A)
      |=> o_rdata[15:13] == 3'h0 && o_rdata[7:5] == 3'h0)
      else $error("reserved capture bits not zero");

   a_mismatch_raise: assert property (
      (st_r.out_map != st_r.out_shadow) |=> o_cfg_mismatch_rst)
      else $error("shadow difference not flagged");

   a_oc1_route: assert property (
      (P_PIN_IMPL[0] && st_r.out_map[0] == `PPSM_FN_OC1)
      |=> o_pin_oe[0] && o_pin_out[0] == $past(i_periph.compare_out_1))
      else $error("compare output not routed");

endmodule

// >>> verif/ppsm_periph_model.sv
// peripheral and pad model: drives peripheral output levels and pin input levels
module ppsm_periph_model (
   input  wire logic                      i_mclk,
   input  wire logic [22:0]               i_periph_set,
   input  wire logic [31:0]               i_pins_set,
   output ppsm_pkg::ppsm_periph_type      o_periph,
   output logic [31:0]                    o_pin_in
);
   timeunit 1ns;
   timeprecision 1ps;

   // ------------------------------------------------------------------------
   // registered levels
   // ------------------------------------------------------------------------
   // levels change only after a clock edge, as real on-chip sources would
   always_ff @(posedge i_mclk) begin
      o_periph <= ppsm_pkg::ppsm_periph_type'(i_periph_set);
      o_pin_in <= i_pins_set;
   end
endmodule

// >>> verif/ppsm_top_tb.sv
// self-checking testbench for the pin select map block
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end

module ppsm_top_tb;
   timeunit 1ns;
   timeprecision 1ps;

   // ------------------------------------------------------------------------
   // signals
   // ------------------------------------------------------------------------
   logic                    clk;
   logic                    srst;
   ppsm_pkg::ppsm_req_type  req;
   ppsm_pkg::ppsm_periph_type periph;
   logic [31:0]             pin_in;
   logic                    cfg;
   logic [22:0]             pset;
   logic [31:0]             pins;
   logic [15:0]             rdata;
   logic [31:0]             pin_out;
   logic [31:0]             pin_oe;
   logic [3:0]              cap_in;
   logic                    lock;
   logic                    mism;
   int                      errors;
   int                      total_checks;
   int                      cycles;
   logic [15:0]             rd_v;
   // periph bit for each output code, -1 where the code connects nothing
   localparam int CODE_BIT [32] = '{-1, 22, 21, 19, 18, 15, 14, 11, 10, 9, 8, 7, 6,
      -1, -1, -1, -1, -1, 5, 4, 3, 2, 1, -1, -1, -1, -1, -1, -1, 0, 20, -1};
   localparam logic [22:0] IR_MODES = 23'h011000;

   ppsm_top u_dut (
      .i_mclk                    (clk),
      .i_srst                    (srst),
      .i_req                     (req),
      .i_periph                  (periph),
      .i_pin_in                  (pin_in),
      .i_single_session_lock_cfg (cfg),
      .o_rdata                   (rdata),
      .o_pin_out                 (pin_out),
      .o_pin_oe                  (pin_oe),
      .o_capture_in              (cap_in),
      .o_map_write_lock          (lock),
      .o_cfg_mismatch_rst        (mism)
   );

   ppsm_periph_model u_model (
      .i_mclk       (clk),
      .i_periph_set (pset),
      .i_pins_set   (pins),
      .o_periph     (periph),
      .o_pin_in     (pin_in)
   );

   // ------------------------------------------------------------------------
   // clock and hang guard
   // ------------------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // whole run needs about 350 cycles, so 6000 leaves ample margin
   always @(posedge clk) begin
      cycles++;
      if (cycles == 6000) begin
         errors++;
         give_verdict();
      end
   end

   // ------------------------------------------------------------------------
   // bus and helper tasks
   // ------------------------------------------------------------------------
   task automatic do_reset();
      @(posedge clk);
      srst <= 1'b1;
      repeat (6) @(posedge clk);
      srst <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      req.addr  <= a;
      req.wdata <= d;
      req.wr    <= 1'b1;
      @(posedge clk);
      req.wr    <= 1'b0;
   endtask

   // read data is only valid in the cycle right after the strobe is taken
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      req.addr <= a;
      req.rd   <= 1'b1;
      @(posedge clk);
      req.rd   <= 1'b0;
      #1 rd_v = rdata;
   endtask

   // unlock keys must precede the lock write itself
   task automatic set_lock(input logic v);
      wr(8'h00, 16'h0046);
      wr(8'h00, 16'h0057);
      wr(8'h00, {9'h000, v, 6'h00});
   endtask

   // model adds one cycle, the map and pin registers two more
   task automatic settle();
      repeat (3) @(posedge clk);
      #1;
   endtask

   task automatic give_verdict();
      $display("checks=%0d mismatches=%0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // ------------------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------------------
   task automatic t_reset();
      #1;
      `CHK(pin_oe, 32'h0000_0000)
      `CHK(lock, 1'b0)
      rd(8'h02);
      `CHK(rd_v, 16'h1F1F)
      rd(8'h03);
      `CHK(rd_v, 16'h1F1F)
      rd(8'h10);
      `CHK(rd_v, 16'h0000)
      rd(8'h40);
      `CHK(rd_v, 16'h0000)
      $display("test reset done");
   endtask

   task automatic t_codes();
      int b;
      for (int c = 0; c < 32; c++) begin
         b = CODE_BIT[c];
         wr(8'h10, {3'h0, 5'(c), 3'h0, 5'(c)});
         pset <= (b < 0) ? ~IR_MODES : 23'(1) << b;
         settle();
         if (b < 0) begin
            `CHK(pin_oe[1:0], 2'b00)
         end else begin
            `CHK(pin_oe[1:0], 2'b11)
            `CHK(pin_out[1:0], 2'b11)
            pset <= ~(23'(1) << b) & ~IR_MODES;
            settle();
            `CHK(pin_out[1:0], 2'b00)
         end
      end
      $display("test codes done");
   endtask

   // with infrared mode on, the request-to-send codes carry the bit clock
   task automatic t_ir();
      wr(8'h10, 16'h0604);
      pset <= 23'h033000;
      settle();
      `CHK(pin_out[1:0], 2'b11)
      pset <= 23'h055000;
      settle();
      `CHK(pin_out[1:0], 2'b00)
      $display("test ir done");
   endtask

   task automatic t_capture();
      wr(8'h02, 16'h0303);
      wr(8'h03, 16'h0C05);
      pins <= 32'h0000_1028;
      settle();
      `CHK(cap_in, 4'b0111)
      pins <= ~32'h0000_0028;
      settle();
      `CHK(cap_in, 4'b0000)
      rd(8'h02);
      `CHK(rd_v, 16'h0303)
      wr(8'h03, 16'hFFFF);
      rd(8'h03);
      `CHK(rd_v, 16'h1F1F)
      $display("test capture done");
   endtask

   // pins 12 and 26 are absent on the 44-pin variant
   task automatic t_unimpl();
      wr(8'h16, 16'h1212);
      wr(8'h1D, 16'h0012);
      pset <= 23'h000020;
      settle();
      `CHK({pin_oe[26], pin_oe[13:12]}, 3'b010)
      `CHK(pin_out[13], 1'b1)
      $display("test unimplemented done");
   endtask

   task automatic t_lock();
      wr(8'h10, 16'h0101);
      set_lock(1'b1);
      #1;
      `CHK(lock, 1'b1)
      rd(8'h00);
      `CHK(rd_v, 16'h0040)
      wr(8'h10, 16'h1212);
      wr(8'h02, 16'h0000);
      rd(8'h10);
      `CHK(rd_v, 16'h0101)
      rd(8'h02);
      `CHK(rd_v, 16'h0303)
      set_lock(1'b0);
      wr(8'h10, 16'h0202);
      wr(8'h11, 16'h0303);
      rd(8'h10);
      `CHK(rd_v, 16'h0202)
      rd(8'h11);
      `CHK(rd_v, 16'h0303)
      $display("test lock done");
   endtask

   // a stray osc write between the keys spoils the sequence
   task automatic t_abort();
      wr(8'h00, 16'h0046);
      wr(8'h00, 16'h0012);
      wr(8'h00, 16'h0040);
      #1;
      `CHK(lock, 1'b0)
      wr(8'h00, 16'h0057);
      wr(8'h00, 16'h0040);
      #1;
      `CHK(lock, 1'b0)
      set_lock(1'b1);
      set_lock(1'b0);
      #1;
      `CHK(lock, 1'b0)
      $display("test abort done");
   endtask

   task automatic t_one_way();
      cfg <= 1'b1;
      do_reset();
      set_lock(1'b1);
      set_lock(1'b0);
      #1;
      `CHK(lock, 1'b1)
      rd(8'h01);
      `CHK(rd_v, 16'h0005)
      `CHK(mism, 1'b0)
      do_reset();
      #1;
      `CHK(lock, 1'b0)
      `CHK(pin_oe, 32'h0000_0000)
      $display("test one-way done");
   endtask

   // ------------------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------------------
   initial begin
      srst = 1'b1;
      req = '0;
      cfg = 1'b0;
      pset = 23'h000000;
      pins = 32'h0000_0000;
      errors = 0;
      total_checks = 0;
      cycles = 0;
      do_reset();
      t_reset();
      t_codes();
      t_ir();
      t_capture();
      t_unimpl();
      t_lock();
      t_abort();
      t_one_way();
      give_verdict();
   end
endmodule
